// *** uebf_pkg.sv ***
package uebf_pkg;

  // Register bus geometry: word index on the bus, byte address is four times it
  localparam int          AW          = 5;
  localparam logic [4:0]  IDX_STATUS  = 5'h10;   // Sticky event bits, write one to clear
  localparam logic [4:0]  IDX_MASK    = 5'h11;   // Interrupt mask, same layout
  localparam int          EV_W        = 3;       // Number of event bits

  // Event bit positions in status and mask
  localparam int          EV_OUT_DONE = 0;
  localparam int          EV_IN_DONE  = 1;
  localparam int          EV_STALL    = 2;

  // Descriptor entry offsets inside one eight-byte block
  localparam logic [2:0]  OFF_CNF     = 3'h0;
  localparam logic [2:0]  OFF_XBASE   = 3'h1;
  localparam logic [2:0]  OFF_XCNT    = 3'h2;
  localparam logic [2:0]  OFF_SPARE_A = 3'h3;
  localparam logic [2:0]  OFF_SPARE_B = 3'h4;
  localparam logic [2:0]  OFF_YBASE   = 3'h5;
  localparam logic [2:0]  OFF_YCNT    = 3'h6;
  localparam logic [2:0]  OFF_SIZE    = 3'h7;

  // Configuration byte field positions
  localparam int          B_BUFFER_MANAGER_ENABLE      = 7;
  localparam int          B_ISO       = 6;
  localparam int          B_TOGGLE    = 5;
  localparam int          B_DOUBLE_BUFFER_ENABLE      = 4;
  localparam int          B_STALL     = 3;
  localparam int          B_IE        = 2;
  // Byte-count entry: flag in bit 7, length below it
  localparam int          B_NAK       = 7;

  // Writable-bit masks per entry kind
  localparam logic [7:0]  MASK_CNF    = 8'hFC;   // Bits 1:0 reserved, read zero
  localparam logic [7:0]  MASK_SIZE   = 8'h7F;   // Bit 7 reserved, read zero
  localparam logic [7:0]  MASK_FULL   = 8'hFF;
  localparam logic [7:0]  MASK_NONE   = 8'h00;

  // Reset values and limits
  localparam logic [7:0]  EDB_RST     = 8'h00;
  localparam logic [2:0]  EV_RST      = 3'h0;
  localparam logic [6:0]  MAX_COUNT   = 7'h40;   // Largest legal count, 64 bytes

  // Handshake the buffer manager should give the host
  typedef enum logic [3:0] {
    HS_NONE  = 4'b0001,
    HS_ACK   = 4'b0010,
    HS_NAK   = 4'b0100,
    HS_STALL = 4'b1000
  } uebf_hs_e;

  // Host-out packet finished by the serial engine
  typedef struct packed {
    logic       req;     // One-cycle pulse, packet received without error
    logic [6:0] len;     // Received length in bytes
  } uebf_out_txn_s;

  // Host-in traffic from the serial engine
  typedef struct packed {
    logic req;           // One-cycle pulse, host-in token seen
    logic ack;           // One-cycle pulse, host acknowledged our data
    logic stall_set;     // One-cycle pulse, engine flags a stall
  } uebf_in_txn_s;

  // Answer for one endpoint
  typedef struct packed {
    uebf_hs_e   hs;
    logic       sel_y;   // Second buffer serves this transaction
    logic [10:0] base;   // Byte address of the selected buffer
    logic [6:0] bytes;   // Out: capacity, in: packet length
  } uebf_ans_s;

  // Stored base bits 10:3 padded to a byte address
  function automatic logic [10:0] uebf_base_addr(input logic [7:0] base);
    return {base, 3'h0};
  endfunction

  // Bits of an entry that software may write and read back
  function automatic logic [7:0] uebf_wr_mask(input logic [2:0] off);
    unique case (off)
      OFF_CNF:                  return MASK_CNF;
      OFF_SIZE:                 return MASK_SIZE;
      OFF_SPARE_A, OFF_SPARE_B: return MASK_NONE;
      default:                  return MASK_FULL;
    endcase
  endfunction

endpackage

// *** uebf_buf_select.sv ***
`timescale 1ns/1ns
module uebf_buf_select
  import uebf_pkg::*;
(
  input  wire logic [7:0]  cnf,      // Configuration byte
  input  wire logic [7:0]  xbase,    // First buffer base entry
  input  wire logic [7:0]  xcnt,     // First buffer count entry
  input  wire logic [7:0]  ybase,    // Second buffer base entry
  input  wire logic [7:0]  ycnt,     // Second buffer count entry
  output wire logic        sel_y,    // Second buffer chosen
  output wire logic [10:0] base,     // Padded start address
  output wire logic [7:0]  cnt       // Count entry of the chosen buffer
);
  import uebf_pkg::*;

  // Single buffering always uses the first buffer; double lets the toggle pick
  assign sel_y = cnf[B_DOUBLE_BUFFER_ENABLE] & cnf[B_TOGGLE];

  // Base is only read here, never written back
  assign base  = uebf_base_addr(sel_y ? ybase : xbase);

  // Count entry of whichever buffer serves
  assign cnt   = sel_y ? ycnt : xcnt;

endmodule

// *** uebf_descriptor_regs.sv ***
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
// How it works
// - Out count flag set means full, NAK
// - Counts run zero to 64 bytes only; the code enforces this on out loads alone, software may write counts up to 127
// - One size field serves both buffers
// - Base entries hold address bits 10:3
// - Hardware never alters stored base addresses
// - Interrupt enable gates completion interrupt
// - Stall bit: set, send STALL; self-clears on the in endpoint only
// - Double buffer off uses first buffer only
// - Toggle bit follows DATA0/DATA1 sequence
// - Enable bit gates buffer manager service
// - In count flag set means empty, NAK
// - Eight-byte descriptor with fixed entry offsets
module uebf_descriptor_regs
  import uebf_pkg::*;
(
  input  wire logic                    clk_sys,          // System clock, 50 MHz
  input  wire logic                    rst_n,            // Asynchronous reset
  input  wire logic [uebf_pkg::AW-1:0] avs_address,      // Word index
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [31:0]             avs_readdata,
  output wire logic                    avs_waitrequest,
  input  wire uebf_pkg::uebf_out_txn_s out_txn,          // Host-out completions
  input  wire uebf_pkg::uebf_in_txn_s  in_txn,           // Host-in traffic
  output wire uebf_pkg::uebf_ans_s     out_ans,          // Out endpoint answer
  output wire uebf_pkg::uebf_ans_s     in_ans,           // In endpoint answer
  output wire logic                    irq               // Level interrupt
);
  import uebf_pkg::*;

  // Descriptor bytes: index 0 is the out endpoint, 1 the in endpoint
  logic [7:0]      edb      [2][8];
  logic [7:0]      next_edb [2][8];
  logic [EV_W-1:0] status;            // Sticky events
  logic [EV_W-1:0] next_status;
  logic [EV_W-1:0] mask;              // Interrupt mask
  logic            served;            // Second bus cycle of a request

  // ---------------- Bus decode ----------------
  wire       bus_req    = avs_read | avs_write;
  wire       bus_take   = bus_req & served;          // Edge that completes it
  wire       byte0      = avs_byteenable[0];
  wire       is_edb     = ~avs_address[4];
  wire       wdir       = avs_address[3];
  wire [2:0] woff       = avs_address[2:0];
  wire [7:0] wmask      = uebf_wr_mask(woff);
  wire [7:0] wbyte      = avs_writedata[7:0];
  wire       wr_edb     = bus_take & avs_write & byte0 & is_edb;
  wire       wr_status  = bus_take & avs_write & byte0 & (avs_address == IDX_STATUS);
  wire       wr_mask    = bus_take & avs_write & byte0 & (avs_address == IDX_MASK);

  // One wait state keeps read data registered yet ready at the taking edge
  assign avs_waitrequest = bus_req & ~served;

  // Read selection; unmapped words read as zero
  wire [7:0] rd_edb  = edb[wdir][woff] & wmask;
  wire [7:0] rd_byte = is_edb                     ? rd_edb :
                       (avs_address == IDX_STATUS) ? {5'h00, status} :
                       (avs_address == IDX_MASK)   ? {5'h00, mask} : 8'h00;

  // ---------------- Out endpoint view ----------------
  wire [7:0]  o_cnf  = edb[0][OFF_CNF];
  wire        o_sel_y;
  wire [10:0] o_base;
  wire [7:0]  o_cnt;

  // Pick the buffer for the out endpoint
  uebf_buf_select u_out_sel (
    .cnf   (o_cnf),
    .xbase (edb[0][OFF_XBASE]),
    .xcnt  (edb[0][OFF_XCNT]),
    .ybase (edb[0][OFF_YBASE]),
    .ycnt  (edb[0][OFF_YCNT]),
    .sel_y (o_sel_y),
    .base  (o_base),
    .cnt   (o_cnt)
  );

  wire [6:0] o_size  = edb[0][OFF_SIZE][6:0];
  // A disabled endpoint is left alone; a full buffer is refused
  wire uebf_hs_e o_hs = !o_cnf[B_BUFFER_MANAGER_ENABLE]  ? HS_NONE :
                        o_cnf[B_STALL]  ? HS_STALL :
                        o_cnt[B_NAK]    ? HS_NAK : HS_ACK;
  // Overlong packets never land, so a received packet never stores an illegal count
  wire       len_ok   = (out_txn.len <= o_size) && (out_txn.len <= MAX_COUNT);
  wire       out_load = out_txn.req & (o_hs == HS_ACK) & len_ok;
  wire [2:0] o_cnt_off = o_sel_y ? OFF_YCNT : OFF_XCNT;

  assign out_ans = '{hs: o_hs, sel_y: o_sel_y, base: o_base, bytes: o_size};

  // ---------------- In endpoint view ----------------
  wire [7:0]  i_cnf  = edb[1][OFF_CNF];
  wire        i_sel_y;
  wire [10:0] i_base;
  wire [7:0]  i_cnt;

  // Pick the buffer for the in endpoint
  uebf_buf_select u_in_sel (
    .cnf   (i_cnf),
    .xbase (edb[1][OFF_XBASE]),
    .xcnt  (edb[1][OFF_XCNT]),
    .ybase (edb[1][OFF_YBASE]),
    .ycnt  (edb[1][OFF_YCNT]),
    .sel_y (i_sel_y),
    .base  (i_base),
    .cnt   (i_cnt)
  );

  // Flag set means nothing to send yet
  wire uebf_hs_e i_hs = !i_cnf[B_BUFFER_MANAGER_ENABLE] ? HS_NONE :
                        i_cnf[B_STALL] ? HS_STALL :
                        i_cnt[B_NAK]   ? HS_NAK : HS_ACK;
  wire       in_done   = in_txn.ack & (i_hs == HS_ACK);
  wire       stall_out = in_txn.req & (i_hs == HS_STALL);
  wire [2:0] i_cnt_off = i_sel_y ? OFF_YCNT : OFF_XCNT;

  assign in_ans = '{hs: i_hs, sel_y: i_sel_y, base: i_base, bytes: i_cnt[6:0]};

  // ---------------- Events and interrupt ----------------
  // Completion events only count when the endpoint asks for them
  wire [EV_W-1:0] events = {stall_out,
                            in_done & i_cnf[B_IE],
                            out_load & o_cnf[B_IE]};
  wire [EV_W-1:0] w1c    = wr_status ? avs_writedata[EV_W-1:0] : EV_RST;

  // Clear first, then set, so an event in the clearing cycle survives
  assign next_status = (status & ~w1c) | events;
  assign irq         = |(status & mask);

  // Next descriptor contents: hardware clear, then software, then hardware sets
  always_comb
  begin
    next_edb = edb;
    // The stall is spent once its handshake went out
    if (stall_out)
      next_edb[1][OFF_CNF][B_STALL] = 1'b0;
    // Software write of one re-arms a stall even in that cycle
    if (wr_edb)
      next_edb[wdir][woff] = (next_edb[wdir][woff] & ~wmask) | (wbyte & wmask);
    // Received length lands with the full flag; base entries untouched
    if (out_load)
    begin
      next_edb[0][o_cnt_off] = {1'b1, out_txn.len};
      next_edb[0][OFF_CNF][B_TOGGLE] = ~o_cnf[B_TOGGLE];
    end
    // Data taken by the host empties the buffer
    if (in_done)
    begin
      next_edb[1][i_cnt_off][B_NAK] = 1'b1;
      next_edb[1][OFF_CNF][B_TOGGLE] = ~i_cnf[B_TOGGLE];
    end
    // The engine may raise a stall on its own
    if (in_txn.stall_set)
      next_edb[1][OFF_CNF][B_STALL] = 1'b1;
  end

  // Descriptor storage
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int d = 0; d < 2; d++)
      begin
        for (int o = 0; o < 8; o++)
        begin
          edb[d][o] <= EDB_RST;
        end
      end
    end
    else
    begin
      edb <= next_edb;
    end
  end

  // Status, mask and bus handshake
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status <= EV_RST;
      mask   <= EV_RST;
      served <= 1'b0;
    end
    else
    begin
      status <= next_status;
      served <= bus_req & ~served;
      if (wr_mask)
        mask <= avs_writedata[EV_W-1:0];
    end
  end

  // Read data is caught on the first cycle and stands through the second
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read & ~served)
      avs_readdata <= {24'h00_0000, rd_byte};
  end

  // ---------------- Checks ----------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  wire [7:0] o_xb = edb[0][OFF_XBASE];
  wire [7:0] o_yb = edb[0][OFF_YBASE];
  wire [7:0] i_xb = edb[1][OFF_XBASE];
  wire [7:0] i_yb = edb[1][OFF_YBASE];

  sequence s_bus_first;
    bus_req && !served;
  endsequence

  sequence s_bus_done;
    !avs_waitrequest && bus_req;
  endsequence

  a_bus_one_wait: assert property (s_bus_first ##1 bus_req |-> s_bus_done)
    else $error("bus request not completed after one wait state");

  // A full out buffer refuses the packet and keeps its count
  a_out_full_nak: assert property (out_txn.req && o_cnf[B_BUFFER_MANAGER_ENABLE] && !o_cnf[B_STALL]
    && o_cnt[B_NAK] && !wr_edb |-> o_hs == HS_NAK ##1 edb[0][o_cnt_off] == $past(o_cnt))
    else $error("full out buffer was not refused");

  a_out_count_load: assert property (out_load |=>
    edb[0][$past(o_cnt_off)] == {1'b1, $past(out_txn.len)})
    else $error("out count not loaded with flag");

  a_count_legal: assert property (out_load |=> edb[0][$past(o_cnt_off)][6:0] <= MAX_COUNT)
    else $error("stored count above 64");

  a_size_rsvd: assert property (edb[0][OFF_SIZE][7] == 1'b0 && edb[1][OFF_SIZE][7] == 1'b0)
    else $error("reserved size bit set");

  // Selection worked out from the raw config bits, not from the selector
  a_base_pad: assert property (o_base ==
    {((o_cnf[B_DOUBLE_BUFFER_ENABLE] && o_cnf[B_TOGGLE]) ? o_yb : o_xb), 3'h0})
    else $error("out base address not padded");

  a_base_kept: assert property ((out_load || in_done) && !wr_edb |=>
    $stable(o_xb) && $stable(o_yb) && $stable(i_xb) && $stable(i_yb))
    else $error("base address changed by hardware");

  a_ie_gate: assert property (in_done && !i_cnf[B_IE] && !stall_out && !wr_status
    |=> status[EV_IN_DONE] == $past(status[EV_IN_DONE]))
    else $error("completion event without interrupt enable");

  a_stall_clear: assert property (stall_out && !wr_edb && !in_txn.stall_set
    |=> !i_cnf[B_STALL] && status[EV_STALL])
    else $error("stall bit not cleared after handshake");

  a_single_buf: assert property (!i_cnf[B_DOUBLE_BUFFER_ENABLE] |-> !i_sel_y && i_base == {i_xb, 3'h0})
    else $error("second buffer used while single buffered");

  a_toggle_flip: assert property (in_done && !wr_edb
    |=> i_cnf[B_TOGGLE] != $past(i_cnf[B_TOGGLE]))
    else $error("in toggle did not advance");

  a_buffer_manager_enable_gate: assert property (!o_cnf[B_BUFFER_MANAGER_ENABLE] && out_txn.req && !wr_edb
    |-> out_ans.hs == HS_NONE ##1 $stable(edb[0][OFF_XCNT]))
    else $error("disabled endpoint was serviced");

  a_in_empty_nak: assert property (in_txn.req && i_cnf[B_BUFFER_MANAGER_ENABLE] && !i_cnf[B_STALL]
    && i_cnt[B_NAK] |-> in_ans.hs == HS_NAK)
    else $error("empty in buffer not refused");

  // Any unmasked event must hold the interrupt line up
  a_irq_level: assert property (|(status & mask) |-> irq)
    else $error("interrupt low with unmasked event");

  // Token arriving while the in endpoint is stalled
  sequence s_stall_token;
    in_txn.req && i_cnf[B_BUFFER_MANAGER_ENABLE] && i_cnf[B_STALL];
  endsequence

  // A stalled, enabled in endpoint answers STALL ahead of NAK or ACK
  a_in_stall_hs: assert property (s_stall_token |-> in_ans.hs == HS_STALL)
    else $error("stalled in endpoint did not answer stall");

  // Double buffering hands the choice to the toggle bit
  a_out_double_buffer_enable_sel: assert property (o_cnf[B_DOUBLE_BUFFER_ENABLE] |-> o_sel_y == o_cnf[B_TOGGLE])
    else $error("out buffer choice ignores toggle");

  // Out toggle advances with every stored packet, whatever firmware wrote
  a_out_toggle: assert property (out_load |=> o_cnf[B_TOGGLE] != $past(o_cnf[B_TOGGLE]))
    else $error("out toggle did not advance");

  // Data taken by the host must leave the buffer marked empty
  a_in_ack_empty: assert property (in_done |=> edb[1][$past(i_cnt_off)][B_NAK])
    else $error("in buffer not marked empty after host ack");

  // Overlong packets leave both count entries alone
  a_out_overlong: assert property (out_txn.req && out_txn.len > MAX_COUNT && !wr_edb
    |=> $stable(edb[0][OFF_XCNT]) && $stable(edb[0][OFF_YCNT]))
    else $error("overlong out packet changed a count");

  // A stored packet on an endpoint that asks for it raises its event
  a_out_event: assert property (out_load && o_cnf[B_IE] |=> status[EV_OUT_DONE])
    else $error("out completion event missing");

endmodule

// *** uebf_host_model.sv ***
`timescale 1ns/1ns
// Serial engine and host behind it, driven by bench commands
module uebf_host_model
  import uebf_pkg::*;
(
  input  wire logic                 clk_sys,     // System clock
  input  wire logic                 rst_n,       // Asynchronous reset
  input  wire logic                 out_go,      // Send one host-out packet
  input  wire logic [6:0]           out_len,     // Its length
  input  wire logic                 in_go,       // Send one host-in token
  input  wire logic                 stall_go,    // Engine flags a stall
  input  wire logic [3:0]           ack_wait,    // Host turnaround before ACK
  input  wire uebf_pkg::uebf_ans_s  out_ans,
  input  wire uebf_pkg::uebf_ans_s  in_ans,
  output uebf_pkg::uebf_out_txn_s   out_txn,
  output uebf_pkg::uebf_in_txn_s    in_txn,
  output uebf_pkg::uebf_hs_e        out_hs_seen, // Handshake of last out packet
  output uebf_pkg::uebf_hs_e        in_hs_seen   // Handshake of last in token
);
  import uebf_pkg::*;

  logic [4:0] ack_cnt;                           // Counts down to host ACK

  // Pulses last one cycle; length inverts between packets so stale data never looks valid
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_txn     <= '0;
      in_txn      <= '0;
      ack_cnt     <= 5'h00;
      out_hs_seen <= HS_NONE;
      in_hs_seen  <= HS_NONE;
    end
    else
    begin
      out_txn.req      <= out_go;
      out_txn.len      <= out_go ? out_len : ~out_txn.len;
      in_txn.req       <= in_go;
      in_txn.stall_set <= stall_go;
      in_txn.ack       <= (ack_cnt == 5'h01);
      if (out_txn.req)
        out_hs_seen <= out_ans.hs;
      if (in_txn.req)
        in_hs_seen <= in_ans.hs;
      // Host acknowledges only data really sent, never a NAK or STALL
      if (in_txn.req && in_ans.hs == HS_ACK)
        ack_cnt <= {1'h0, ack_wait} + 5'h01;
      else if (ack_cnt != 5'h00)
        ack_cnt <= ack_cnt - 5'h01;
    end
  end
endmodule

// *** test_usb_endpoint_descriptor_fields.sv ***
`timescale 1ns/1ns
// Self-checking bench: register bus on one side, host model on the other
module test_usb_endpoint_descriptor_fields;
  import uebf_pkg::*;
  logic          clk_sys;
  logic          rst_n;
  logic [4:0]    avs_address;
  logic          avs_read;
  logic          avs_write;
  logic [31:0]   avs_writedata;
  logic [3:0]    avs_byteenable;
  logic [31:0]   avs_readdata;
  logic          avs_waitrequest;
  logic          out_go;
  logic [6:0]    out_len;
  logic          in_go;
  logic          stall_go;
  logic [3:0]    ack_wait;
  uebf_out_txn_s out_txn;
  uebf_in_txn_s  in_txn;
  uebf_ans_s     out_ans;
  uebf_ans_s     in_ans;
  logic          irq;
  uebf_hs_e      out_hs_seen;
  uebf_hs_e      in_hs_seen;
  logic [31:0]   rdata;          // Last read word
  int            error_cnt = 0;
  int            checks = 0;
  int            cyc = 0;        // Cycles run, for the hang guard

  uebf_descriptor_regs i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .out_txn(out_txn), .in_txn(in_txn), .out_ans(out_ans), .in_ans(in_ans), .irq(irq));
  uebf_host_model i_host (.clk_sys(clk_sys), .rst_n(rst_n), .out_go(out_go),
    .out_len(out_len), .in_go(in_go), .stall_go(stall_go), .ack_wait(ack_wait),
    .out_ans(out_ans), .in_ans(in_ans), .out_txn(out_txn), .in_txn(in_txn),
    .out_hs_seen(out_hs_seen), .in_hs_seen(in_hs_seen));

  // 20 ns clock
  initial
  begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      finish_test;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // One bus cycle, held until waitrequest is sampled low; an extra edge keeps strobes apart
  task automatic bus(input logic wr_n_rd, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_write     <= wr_n_rd;
    avs_read      <= ~wr_n_rd;
    avs_writedata <= {24'h000000, d};
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (avs_waitrequest !== 1'h0);
    rdata = avs_readdata;
    // Only the hang guard ends a wait; the slave promises one wait state
    chk("bus wait edges", 32'h2, n);
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    bus(1'h0, a, 8'h00);
    chk($sformatf("reg %h", a), {24'h000000, e}, rdata);
  endtask

  task automatic host_out(input logic [6:0] len);
    out_len <= len;
    out_go  <= 1'h1;
    @(posedge clk_sys);
    out_go  <= 1'h0;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic host_in;
    in_go <= 1'h1;
    @(posedge clk_sys);
    in_go <= 1'h0;
    repeat (10) @(posedge clk_sys);
  endtask

  task automatic t_reset;
    rd(5'h00, 8'h00);
    rd(5'h08, 8'h00);
    rd(5'h10, 8'h00);
    chk("out hs", HS_NONE, out_ans.hs);
    chk("in hs", HS_NONE, in_ans.hs);
    chk("irq", 32'h0, irq);
    $display("test reset done");
  endtask

  // Reserved size bit, spare offset and unmapped word
  task automatic t_regs;
    wr(5'h07, 8'hC0);
    rd(5'h07, 8'h40);
    avs_byteenable <= 4'hE;
    wr(5'h01, 8'hFF);
    avs_byteenable <= 4'hF;
    rd(5'h01, 8'h00);
    wr(5'h03, 8'hFF);
    rd(5'h03, 8'h00);
    wr(5'h12, 8'hFF);
    rd(5'h12, 8'h00);
    $display("test regs done");
  endtask

  // Single-buffered out endpoint: store, NAK, re-arm, overlong drop
  task automatic t_out;
    wr(5'h11, 8'h01);
    wr(5'h01, 8'h5A);
    wr(5'h07, 8'h40);
    wr(5'h00, 8'h84);
    chk("out hs", HS_ACK, out_ans.hs);
    chk("out base", 32'h2D0, out_ans.base);
    chk("out bytes", 32'h40, out_ans.bytes);
    host_out(7'h40);
    chk("out seen", HS_ACK, out_hs_seen);
    rd(5'h02, 8'hC0);
    chk("out hs", HS_NAK, out_ans.hs);
    chk("out sel", 32'h0, out_ans.sel_y);
    rd(5'h00, 8'hA4);
    rd(5'h01, 8'h5A);
    rd(5'h10, 8'h01);
    chk("irq", 32'h1, irq);
    host_out(7'h05);
    chk("out seen", HS_NAK, out_hs_seen);
    rd(5'h02, 8'hC0);
    wr(5'h10, 8'h01);
    chk("irq", 32'h0, irq);
    wr(5'h02, 8'h00);
    chk("out hs", HS_ACK, out_ans.hs);
    host_out(7'h41);
    rd(5'h02, 8'h00);
    $display("test out done");
  endtask

  // Double buffering: toggle picks the buffer
  task automatic t_double_buffer_enable;
    wr(5'h00, 8'h90);
    wr(5'h05, 8'h11);
    chk("out sel", 32'h0, out_ans.sel_y);
    host_out(7'h03);
    rd(5'h02, 8'h83);
    chk("out sel", 32'h1, out_ans.sel_y);
    chk("out base", 32'h088, out_ans.base);
    chk("out hs", HS_ACK, out_ans.hs);
    host_out(7'h05);
    rd(5'h06, 8'h85);
    chk("out hs", HS_NAK, out_ans.hs);
    rd(5'h10, 8'h00);
    wr(5'h00, 8'h10);
    host_out(7'h01);
    chk("out seen", HS_NONE, out_hs_seen);
    rd(5'h02, 8'h83);
    $display("test double_buffer_enable done");
  endtask

  // In endpoint: slow host ACK, stall paths, masking, disabled endpoint
  task automatic t_in;
    wr(5'h11, 8'h07);
    wr(5'h09, 8'h33);
    wr(5'h0A, 8'h0A);
    wr(5'h08, 8'h84);
    chk("in hs", HS_ACK, in_ans.hs);
    chk("in bytes", 32'h0A, in_ans.bytes);
    chk("in base", 32'h198, in_ans.base);
    chk("in sel", 32'h0, in_ans.sel_y);
    ack_wait <= 4'h3;
    host_in;
    rd(5'h0A, 8'h8A);
    chk("in hs", HS_NAK, in_ans.hs);
    rd(5'h08, 8'hA4);
    rd(5'h10, 8'h02);
    wr(5'h08, 8'hAC);
    chk("in hs", HS_STALL, in_ans.hs);
    host_in;
    chk("in seen", HS_STALL, in_hs_seen);
    rd(5'h08, 8'hA4);
    rd(5'h10, 8'h06);
    stall_go <= 1'h1;
    @(posedge clk_sys);
    stall_go <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rd(5'h08, 8'hAC);
    wr(5'h08, 8'hA4);
    rd(5'h08, 8'hA4);
    wr(5'h11, 8'h00);
    chk("irq", 32'h0, irq);
    wr(5'h10, 8'h06);
    rd(5'h10, 8'h00);
    wr(5'h08, 8'hA0);
    wr(5'h0A, 8'h0A);
    host_in;
    rd(5'h0A, 8'h8A);
    rd(5'h10, 8'h00);
    wr(5'h08, 8'h24);
    chk("in hs", HS_NONE, in_ans.hs);
    host_in;
    chk("in seen", HS_NONE, in_hs_seen);
    rd(5'h0A, 8'h8A);
    $display("test in done");
  endtask

  initial
  begin
    rst_n         = 1'h0;
    avs_address   = 5'h00;
    avs_read      = 1'h0;
    avs_write     = 1'h0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    out_go        = 1'h0;
    out_len       = 7'h00;
    in_go         = 1'h0;
    stall_go      = 1'h0;
    ack_wait      = 4'h0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    t_reset;
    t_regs;
    t_out;
    t_double_buffer_enable;
    t_in;
    finish_test;
  end
endmodule
